// File: pkg/jmm_pkg.sv
// jmm_pkg: shared constants and carriers for the jump / modify-memory executor
// assumes a 16-bit word machine with bit 0 as the most significant bit
package jmm_pkg;
   localparam int WORD_W = 16;
   // instruction fields, numbered with bit 0 as msb (vector index = 15 - bit)
   localparam int OPC_HI = 15;          // bit 0
   localparam int OPC_LO = 13;          // bits 0..2 must be zero
   localparam int SUB_HI = 12;          // bit 3
   localparam int SUB_LO = 11;          // bit 4
   localparam int IND_POS = 10;         // bit 5
   localparam int MODE_HI = 9;          // bit 6
   localparam int MODE_LO = 8;          // bit 7
   localparam int DISP_HI = 7;          // bit 8, sign
   localparam int DISP_LO = 0;          // bit 15
   localparam int DISP_W = 8;
   localparam logic [2:0] OPC_GROUP = 3'h0;
   localparam logic [15:0] ZERO_WORD = 16'h0000;
   localparam logic [15:0] ONE_WORD = 16'h0001;

   typedef enum logic [1:0] {
      JMM_JUMP = 2'b00,
      JMM_SUBR = 2'b01,
      JMM_INC = 2'b10,
      JMM_DEC = 2'b11
   } jmm_op_type;

   typedef enum logic [1:0] {
      JMM_PAGE0 = 2'b00,
      JMM_REL = 2'b01,
      JMM_BASE2 = 2'b10,
      JMM_BASE3 = 2'b11
   } jmm_mode_type;

   // memory request carrier
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } jmm_mem_req_type;
endpackage

// File: verilog/jmm_ea_calc.sv
// jmm_ea_calc: effective address from index mode and displacement
// assumes pc and accumulators are stable while the executor samples the result
`timescale 1ns/10ps
module jmm_ea_calc #(
   parameter int WORD_W = 16
) (
   input wire logic [15:0] i_instr,
   input wire logic [WORD_W-1:0] i_pc,
   input wire logic [WORD_W-1:0] i_acc_two,
   input wire logic [WORD_W-1:0] i_acc_three,
   output logic [WORD_W-1:0] o_ea
);
   logic [WORD_W-1:0] disp_u;
   logic [WORD_W-1:0] disp_s;
   logic [1:0] mode;

   // elaboration check: the sign extension needs room above the displacement
   if (WORD_W <= jmm_pkg::DISP_W) begin : g_width_check
      $error("jmm_ea_calc: WORD_W must exceed the displacement width");
   end

   // unsigned and sign-extended displacement
   assign disp_u = {{(WORD_W-jmm_pkg::DISP_W){1'b0}},
                    i_instr[jmm_pkg::DISP_HI:jmm_pkg::DISP_LO]};
   assign disp_s = {{(WORD_W-jmm_pkg::DISP_W){i_instr[jmm_pkg::DISP_HI]}},
                    i_instr[jmm_pkg::DISP_HI:jmm_pkg::DISP_LO]};
   assign mode = i_instr[jmm_pkg::MODE_HI:jmm_pkg::MODE_LO];

   // base selection and add, modulo word
   always_comb begin
      unique case (mode)
         jmm_pkg::JMM_PAGE0: o_ea = disp_u;         // RQ11 RQ12
         jmm_pkg::JMM_REL: o_ea = i_pc + disp_s;    // RQ10 RQ13
         jmm_pkg::JMM_BASE2: o_ea = i_acc_two + disp_s; // RQ13
         jmm_pkg::JMM_BASE3: o_ea = i_acc_three + disp_s; // RQ13 RQ4
      endcase
   end
endmodule

// File: verilog/jmm_exec.sv
// jmm_exec: executes jump, subroutine jump, increment/decrement-skip instructions
// assumes memory answers a read with o_mem.rd held until i_mem_ack, same for writes
// Functional notes
// RQ1: bits 0-2 zero select this group; bits 3-4 choose the operation.
// RQ2: jump loads the program counter with the effective address.
// RQ3: subroutine jump saves incremented pc in accumulator three, then jumps.
// RQ4: base mode on accumulator three returns to its address plus displacement.
// RQ5: increment op reads the word, adds one, writes it back.
// RQ6: zero result after increment skips the next instruction.
// RQ7: decrement op reads the word, subtracts one, writes it back.
// RQ8: zero result after decrement skips the next instruction.
// RQ9: bit 5 set selects indirect addressing, clear selects direct.
// RQ10: index mode 01 uses the program counter as base.
// RQ11: index mode 00 is page zero, combinable with indirect.
// RQ12: page-zero address equals the unsigned eight-bit displacement.
// RQ13: relative and base modes add a sign-extended eight-bit displacement.
// RQ14: indirect fetches an address word from the effective address first.
// RQ15: increment and decrement wrap at sixteen bits and touch no carry.
`timescale 1ns/10ps
module jmm_exec #(
   parameter int WORD_W = 16
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_start,
   input wire logic [15:0] i_instr,
   input wire logic [WORD_W-1:0] i_pc,
   input wire logic [WORD_W-1:0] i_acc_two,
   input wire logic [WORD_W-1:0] i_acc_three,
   input wire logic [WORD_W-1:0] i_mem_rdata,
   input wire logic i_mem_ack,
   output logic o_busy,
   output logic o_accept,
   output logic o_illegal,
   output jmm_pkg::jmm_mem_req_type o_mem,
   output logic o_pc_load,
   output logic [WORD_W-1:0] o_pc_value,
   output logic o_acc_three_load,
   output logic [WORD_W-1:0] o_acc_three_value,
   output logic o_done
);
   // elaboration check: the datapath is built for one word width
   if (WORD_W != jmm_pkg::WORD_W) begin : g_width_check
      $error("jmm_exec: WORD_W must be 16");
   end

   typedef enum logic [2:0] {
      JMM_IDLE = 3'b000,
      JMM_IND = 3'b001,
      JMM_EXEC = 3'b010,
      JMM_READ = 3'b011,
      JMM_WRITE = 3'b100,
      JMM_JUMP_ST = 3'b101,
      JMM_FIN = 3'b110
   } jmm_state_type;

   // decoding used at start and reported on the accept handshake
   function automatic logic is_group(input logic [15:0] w);
      is_group = (w[jmm_pkg::OPC_HI:jmm_pkg::OPC_LO] == jmm_pkg::OPC_GROUP);
   endfunction

   // increment and decrement both go through memory
   function automatic logic is_mem_op(input jmm_pkg::jmm_op_type o);
      is_mem_op = (o == jmm_pkg::JMM_INC) || (o == jmm_pkg::JMM_DEC);
   endfunction

   jmm_state_type state;
   jmm_state_type next_state;
   logic [15:0] instr;
   logic [15:0] next_instr;
   logic [WORD_W-1:0] ea;
   logic [WORD_W-1:0] next_ea;
   logic [WORD_W-1:0] pc_hold;
   logic [WORD_W-1:0] next_pc_hold;
   logic [WORD_W-1:0] word;
   logic [WORD_W-1:0] next_word;
   jmm_pkg::jmm_mem_req_type next_mem;
   logic next_pc_load;
   logic [WORD_W-1:0] next_pc_value;
   logic next_acc_three_load;
   logic [WORD_W-1:0] next_acc_three_value;
   logic next_done;
   logic next_illegal;
   logic [WORD_W-1:0] ea_calc;
   jmm_pkg::jmm_op_type op;
   // decoded step conditions
   logic take;
   logic refuse;
   logic is_inc;
   logic zero_result;

   jmm_ea_calc #(
      .WORD_W(WORD_W)
   ) u_ea (
      .i_instr(i_instr),
      .i_pc(i_pc),
      .i_acc_two(i_acc_two),
      .i_acc_three(i_acc_three),
      .o_ea(ea_calc)
   );

   assign op = jmm_pkg::jmm_op_type'(instr[jmm_pkg::SUB_HI:jmm_pkg::SUB_LO]); // RQ1
   assign o_busy = (state != JMM_IDLE);
   assign o_accept = take && i_ce;

   // start decode: a group word is taken, any other word is refused
   assign take = (state == JMM_IDLE) && i_start && is_group(i_instr); // RQ1
   assign refuse = (state == JMM_IDLE) && i_start && !is_group(i_instr); // RQ1
   // operation flags of the latched instruction
   assign is_inc = (op == jmm_pkg::JMM_INC);
   assign zero_result = (word == jmm_pkg::ZERO_WORD); // RQ6 RQ8

   // sequencer: next step of the instruction
   always_comb begin
      next_state = state;
      unique case (state)
         JMM_IDLE: begin
            if (take) begin
               if (i_instr[jmm_pkg::IND_POS]) begin // RQ9
                  next_state = JMM_IND; // RQ14
               end else begin
                  next_state = JMM_EXEC;
               end
            end
         end
         JMM_IND: begin
            if (i_mem_ack) begin
               next_state = JMM_EXEC;
            end
         end
         JMM_EXEC: begin
            if (is_mem_op(op)) begin
               next_state = JMM_READ;
            end else begin
               next_state = JMM_JUMP_ST;
            end
         end
         JMM_READ: begin
            if (i_mem_ack) begin
               next_state = JMM_WRITE;
            end
         end
         JMM_WRITE: begin
            if (i_mem_ack) begin
               next_state = JMM_FIN;
            end
         end
         JMM_JUMP_ST: begin
            next_state = JMM_FIN;
         end
         JMM_FIN: begin
            next_state = JMM_IDLE;
         end
         default: begin
            next_state = JMM_IDLE;
         end
      endcase
   end

   // sequencer register, frozen while clock enable is low
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         state <= JMM_IDLE;
      end else if (i_ce) begin
         state <= next_state;
      end
   end

   // operand latch: instruction, address, pc and modified word
   always_comb begin
      next_instr = instr;
      next_ea = ea;
      next_pc_hold = pc_hold;
      next_word = word;
      // operands are captured on the accepting edge only
      if (take) begin
         next_instr = i_instr;
         next_ea = ea_calc;
         next_pc_hold = i_pc;
      end
      // single-level indirection replaces the address once
      if (state == JMM_IND && i_mem_ack) begin
         next_ea = i_mem_rdata; // RQ14
      end
      if (state == JMM_READ && i_mem_ack) begin
         if (is_inc) begin
            next_word = i_mem_rdata + jmm_pkg::ONE_WORD; // RQ5 RQ15
         end else begin
            next_word = i_mem_rdata - jmm_pkg::ONE_WORD; // RQ7 RQ15
         end
      end
   end

   // operand registers
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         instr <= jmm_pkg::ZERO_WORD;
         ea <= '0;
         pc_hold <= '0;
         word <= '0;
      end else if (i_ce) begin
         instr <= next_instr;
         ea <= next_ea;
         pc_hold <= next_pc_hold;
         word <= next_word;
      end
   end

   // memory request: rd or wr stands until its ack edge
   always_comb begin
      next_mem = o_mem;
      unique case (state)
         JMM_IDLE: begin
            if (take && i_instr[jmm_pkg::IND_POS]) begin
               next_mem.rd = 1'b1; // RQ14
               next_mem.addr = ea_calc;
            end
         end
         JMM_IND: begin
            if (i_mem_ack) begin
               next_mem.rd = 1'b0;
            end
         end
         JMM_EXEC: begin
            if (is_mem_op(op)) begin
               next_mem.rd = 1'b1; // RQ5 RQ7
               next_mem.addr = ea;
            end
         end
         JMM_READ: begin
            if (i_mem_ack) begin
               next_mem.rd = 1'b0;
               next_mem.wr = 1'b1;
               next_mem.wdata = next_word;
            end
         end
         JMM_WRITE: begin
            if (i_mem_ack) begin
               next_mem.wr = 1'b0;
            end
         end
         default: begin
            next_mem = o_mem;
         end
      endcase
   end

   // memory request register
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_mem <= '0;
      end else if (i_ce) begin
         o_mem <= next_mem;
      end
   end

   // results: pc and accumulator loads, done and refusal pulses
   always_comb begin
      next_pc_load = 1'b0;
      next_pc_value = o_pc_value;
      next_acc_three_load = 1'b0;
      next_acc_three_value = o_acc_three_value;
      next_done = (state == JMM_FIN);
      next_illegal = refuse; // RQ1
      // return address is saved one cycle ahead of the jump
      if (state == JMM_EXEC && op == jmm_pkg::JMM_SUBR) begin
         next_acc_three_load = 1'b1; // RQ3
         next_acc_three_value = pc_hold + jmm_pkg::ONE_WORD;
      end
      if (state == JMM_JUMP_ST) begin
         next_pc_load = 1'b1; // RQ2 RQ3 RQ4
         next_pc_value = ea;
      end
      // modify ops resume after the instruction, one further on zero
      if (state == JMM_WRITE && i_mem_ack) begin
         next_pc_load = 1'b1;
         if (zero_result) begin
            next_pc_value = pc_hold + jmm_pkg::ONE_WORD + jmm_pkg::ONE_WORD; // RQ6 RQ8
         end else begin
            next_pc_value = pc_hold + jmm_pkg::ONE_WORD;
         end
      end
   end

   // result registers
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_pc_load <= 1'b0;
         o_pc_value <= '0;
         o_acc_three_load <= 1'b0;
         o_acc_three_value <= '0;
         o_done <= 1'b0;
         o_illegal <= 1'b0;
      end else if (i_ce) begin
         o_pc_load <= next_pc_load;
         o_pc_value <= next_pc_value;
         o_acc_three_load <= next_acc_three_load;
         o_acc_three_value <= next_acc_three_value;
         o_done <= next_done;
         o_illegal <= next_illegal;
      end
   end
endmodule

// File: dv/jmm_mem_model.sv
// main memory partner: answers each rd or wr after i_wait idle cycles
// expects the executor to hold its request until the ack edge
`timescale 1ns/10ps
module jmm_mem_model (
   input wire logic i_ref_clk,
   input wire jmm_pkg::jmm_mem_req_type i_mem,
   input wire logic [3:0] i_wait,
   output logic o_ack,
   output logic [15:0] o_rdata
);
   logic [15:0] mem [0:65535];
   int n = 0;
   initial o_ack = 0;
   initial o_rdata = 0;
   // one-cycle ack, read data scrambled once released
   always @(posedge i_ref_clk) begin
      #1;
      if (o_ack) begin
         o_ack = 0;
         o_rdata = ~o_rdata;
      end else if (i_mem.rd || i_mem.wr) begin
         if (n < i_wait) begin
            n++;
         end else begin
            n = 0;
            o_ack = 1;
            if (i_mem.rd) o_rdata = mem[i_mem.addr];
            else mem[i_mem.addr] = i_mem.wdata;
         end
      end
   end
endmodule

// File: dv/jmm_exec_asserts.sv
// port timing checks for jmm_exec
// bound to every jmm_exec instance, one clock domain
`timescale 1ns/10ps
module jmm_exec_asserts (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_start,
   input wire logic [15:0] i_instr,
   input wire logic i_mem_ack,
   input wire logic o_busy,
   input wire logic o_accept,
   input wire logic o_illegal,
   input wire jmm_pkg::jmm_mem_req_type o_mem,
   input wire logic o_pc_load,
   input wire logic o_acc_three_load,
   input wire logic o_done
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   // decode and sequencing
   illegal_pulse_a: assert property (
      i_ce && i_start && !o_busy && i_instr[15:13] != 3'h0 |=> o_illegal) else $error("no illegal");
   accept_group_a: assert property (
      o_accept |-> i_start && !o_busy && i_instr[15:13] == 3'h0) else $error("bad accept");
   jsr_order_a: assert property (
      o_acc_three_load |=> o_pc_load) else $error("pc load not after save");
   pc_done_a: assert property (o_pc_load |=> o_done) else $error("no done");
   done_idle_a: assert property (o_done |=> !o_busy) else $error("busy after done");
   finish_bound_a: assert property (
      o_accept |-> ##[3:40] o_done) else $error("no finish");
   // memory handshake
   rd_hold_a: assert property (
      o_mem.rd && !i_mem_ack |=> o_mem.rd && $stable(o_mem.addr)) else $error("rd dropped");
   wr_hold_a: assert property (
      o_mem.wr && !i_mem_ack |=> o_mem.wr && $stable(o_mem.wdata)) else $error("wr dropped");
   mem_excl_a: assert property (!(o_mem.rd && o_mem.wr)) else $error("rd and wr");
   cover property (o_acc_three_load);
   cover property (o_mem.wr && i_mem_ack);
   cover property (o_illegal);
endmodule
bind jmm_exec jmm_exec_asserts chk_u (
   .i_ref_clk(i_ref_clk),
   .i_rst(i_rst),
   .i_ce(i_ce),
   .i_start(i_start),
   .i_instr(i_instr),
   .i_mem_ack(i_mem_ack),
   .o_busy(o_busy),
   .o_accept(o_accept),
   .o_illegal(o_illegal),
   .o_mem(o_mem),
   .o_pc_load(o_pc_load),
   .o_acc_three_load(o_acc_three_load),
   .o_done(o_done)
);

// File: dv/tb.sv
// self-checking bench for jmm_exec with memory partner
// needs jmm_pkg, the design and dv models compiled first
`timescale 1ns/10ps
`define CHK(n, e, s) begin logic [31:0] ev, sv; ev = (e); sv = (s); checks_done++; \
   if (sv !== ev) begin fail_count++; $display("mismatch %s exp %h got %h", n, ev, sv); end end
module tb;
   logic i_ref_clk = 0, i_rst = 1, i_ce = 1, i_start = 0, i_mem_ack;
   logic [15:0] i_instr = 0, i_pc = 0, i_acc_two = 0, i_acc_three = 0, i_mem_rdata;
   logic [3:0] wait_n = 0;
   logic o_busy, o_accept, o_illegal, o_pc_load, o_acc_three_load, o_done;
   logic [15:0] o_pc_value, o_acc_three_value;
   jmm_pkg::jmm_mem_req_type o_mem;
   int fail_count = 0, checks_done = 0, cyc = 0;
   logic [15:0] qp[$], qa[$];
   logic [31:0] qw[$];
   jmm_exec dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce), .i_start(i_start),
      .i_instr(i_instr), .i_pc(i_pc), .i_acc_two(i_acc_two), .i_acc_three(i_acc_three),
      .i_mem_rdata(i_mem_rdata), .i_mem_ack(i_mem_ack), .o_busy(o_busy),
      .o_accept(o_accept), .o_illegal(o_illegal), .o_mem(o_mem), .o_pc_load(o_pc_load),
      .o_pc_value(o_pc_value), .o_acc_three_load(o_acc_three_load),
      .o_acc_three_value(o_acc_three_value), .o_done(o_done));
   jmm_mem_model mem_u (.i_ref_clk(i_ref_clk), .i_mem(o_mem), .i_wait(wait_n),
      .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
   initial forever #10 i_ref_clk = ~i_ref_clk;
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // cycle ceiling against hangs
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         report_and_stop();
      end
   end
   // outputs against the oldest noted result
   always @(negedge i_ref_clk) begin
      if (o_pc_load === 1'b1) `CHK("pc", qp.pop_front(), o_pc_value)
      if (o_acc_three_load === 1'b1) `CHK("acc3", qa.pop_front(), o_acc_three_value)
      if (o_mem.wr === 1'b1 && i_mem_ack === 1'b1)
         `CHK("wr", qw.pop_front(), {o_mem.addr, o_mem.wdata})
   end
   // one group instruction; md is indirect bit over index mode
   task automatic run(input logic [1:0] op, input logic [2:0] md, input logic z);
      logic [15:0] ea, b, w;
      @(posedge i_ref_clk);
      #1;
      i_instr = {3'h0, op, md, 8'($urandom)};
      i_pc = $urandom;
      i_acc_two = $urandom;
      i_acc_three = $urandom;
      wait_n = $urandom_range(0, 3);
      i_start = 1;
      b = md[1:0] == 2'b01 ? i_pc : md[1:0] == 2'b10 ? i_acc_two : i_acc_three;
      ea = md[1:0] == 2'b00 ? {8'h00, i_instr[7:0]} : b + {{8{i_instr[7]}}, i_instr[7:0]};
      if (md[2]) begin
         mem_u.mem[ea] = ~ea;
         ea = ~ea;
      end
      w = z ? (op[0] ? 16'h0001 : 16'hffff) : 16'($urandom);
      mem_u.mem[ea] = w;
      w = op[0] ? w - 16'h0001 : w + 16'h0001;
      if (op == 2'b01) qa.push_back(i_pc + 16'h0001);
      if (op[1]) qw.push_back({ea, w});
      qp.push_back(op[1] ? i_pc + 16'h0001 + (w == 16'h0000) : ea);
      @(negedge i_ref_clk);
      `CHK("accept", 1'b1, o_accept)
      @(posedge i_ref_clk);
      #1 i_start = 0;
      while (o_done !== 1'b1) @(negedge i_ref_clk);
   endtask
   initial begin
      void'($urandom(90));
      repeat (3) @(posedge i_ref_clk);
      #1 i_rst = 0;
      // opcodes outside the group only pulse illegal
      repeat (4) begin
         @(posedge i_ref_clk);
         #1 i_instr = {3'($urandom_range(7, 1)), 13'($urandom)};
         i_start = 1;
         @(posedge i_ref_clk);
         #1 i_start = 0;
         @(negedge i_ref_clk);
         `CHK("illegal", 2'b10, {o_illegal, o_busy})
      end
      // a group word offered while clock enable is low is not taken
      @(posedge i_ref_clk);
      #1 i_ce = 0;
      i_instr = {3'h0, 13'($urandom)};
      i_start = 1;
      @(negedge i_ref_clk);
      `CHK("frozen accept", 1'b0, o_accept)
      @(posedge i_ref_clk);
      #1 i_start = 0;
      i_ce = 1;
      @(negedge i_ref_clk);
      `CHK("frozen", 2'b00, {o_busy, o_illegal})
      // every op, mode and indirect, with and without a zero result
      for (int k = 0; k < 128; k++) run(k[1:0], k[4:2], k[5]);
      repeat (3) @(posedge i_ref_clk);
      `CHK("queues", 0, qp.size() + qa.size() + qw.size())
      report_and_stop();
   end
endmodule
